// ---- design/cspc_core.sv ----
// program counter, call stack, data stack and port access sequencer
// assumes program memory and data RAM answer reads in the next cycle, I/O in the same
module cspc_core (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic intr_req_i,
    input wire logic [7:0] prog_data_i,
    input wire logic [7:0] ram_rdata_i,
    input wire logic [7:0] io_rdata_i,
    output logic [13:0] prog_addr_o,
    output logic [7:0] ram_addr_o,
    output logic [7:0] ram_wdata_o,
    output logic ram_we_o,
    output logic [7:0] io_addr_o,
    output logic [7:0] io_wdata_o,
    output logic io_we_o,
    output logic io_re_o,
    output logic intr_ack_o,
    output logic intr_en_o,
    output logic [7:0] acc_o,
    output logic [7:0] index_o,
    output logic carry_o,
    output logic zero_o,
    output logic [7:0] call_sp_o,
    output logic [7:0] data_sp_o
);
    typedef enum logic [7:0] {
        ST_FETCH = 8'h01,
        ST_OPER = 8'h02,
        ST_EXEC = 8'h04,
        ST_PUSH1 = 8'h08,
        ST_PUSH2 = 8'h10,
        ST_POP2 = 8'h20,
        ST_POP1 = 8'h40,
        ST_WAIT = 8'h80
    } cspc_state_t;

    cspc_state_t state;
    logic [13:0] instr_pointer;
    logic [7:0] opcode;
    logic [7:0] operand;
    logic [4:0] wait_cnt;
    logic [7:0] hold_byte;
    logic is_intr;
    logic is_iret;
    logic csp_inc, csp_dec, csp_load;
    logic dsp_inc, dsp_dec, dsp_load;
    logic [7:0] csp_val;
    logic [7:0] dsp_val;

    // instructions carrying a second byte
    function automatic logic two_byte(input logic [7:0] op);
        two_byte = (op[7:4] == cspc_pkg::OP_CALL_A_HI) || (op[7:4] >= cspc_pkg::OP_JMP_HI)
            || (op == cspc_pkg::OP_MOV_A_DATA) || (op == cspc_pkg::OP_MOV_A_DIR)
            || (op == cspc_pkg::OP_MOV_A_IDX) || (op == cspc_pkg::OP_MOV_X_DATA)
            || (op == cspc_pkg::OP_MOV_X_DIR) || (op == cspc_pkg::OP_PORT_RD)
            || (op == cspc_pkg::OP_PORT_WR) || (op == cspc_pkg::OP_PORT_WRX);
    endfunction : two_byte

    // call opcodes in both ranges
    function automatic logic is_call(input logic [7:0] op);
        is_call = (op[7:4] == cspc_pkg::OP_CALL_A_HI) || (op[7:4] == cspc_pkg::OP_CALL_B_HI);
    endfunction : is_call

    // total cycle budget per opcode; the sequencer pads to it
    function automatic logic [4:0] cycles_of(input logic [7:0] op);
        if (is_call(op)) begin
            cycles_of = cspc_pkg::CYC_CALL;
        end else if (op == cspc_pkg::OP_SUB_RET || op == cspc_pkg::OP_INTR_RET) begin
            cycles_of = cspc_pkg::CYC_RET;
        end else if (op == cspc_pkg::OP_MOV_A_DIR || op == cspc_pkg::OP_MOV_X_DIR) begin
            cycles_of = cspc_pkg::CYC_DIRECT;
        end else if (op == cspc_pkg::OP_MOV_A_IDX) begin
            cycles_of = cspc_pkg::CYC_INDEX;
        end else if (op == cspc_pkg::OP_POP_A) begin
            cycles_of = cspc_pkg::CYC_POP;
        end else if (op[7:4] == cspc_pkg::OP_JMP_HI) begin
            cycles_of = cspc_pkg::CYC_JMP;
        end else begin
            cycles_of = cspc_pkg::CYC_DEFAULT;
        end
    endfunction : cycles_of

    // low-byte step without carry into the page bits
    function automatic logic [13:0] step_ip(input logic [13:0] ip);
        step_ip = {ip[13:8], ip[7:0] + 8'h01};
    endfunction : step_ip

    assign prog_addr_o = instr_pointer;
    assign call_sp_o = csp_val;
    assign data_sp_o = dsp_val;

    cspc_stack_ptr #(
        .RESET_VAL(cspc_pkg::CSP_RESET)
    ) u_call_sp (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .inc_i(csp_inc),
        .dec_i(csp_dec),
        .load_i(csp_load),
        .load_val_i(acc_o),
        .ptr_o(csp_val)
    );

    cspc_stack_ptr #(
        .RESET_VAL(cspc_pkg::DSP_RESET)
    ) u_data_sp (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .inc_i(dsp_inc),
        .dec_i(dsp_dec),
        .load_i(dsp_load),
        .load_val_i(acc_o),
        .ptr_o(dsp_val)
    );

    // pointer strobes decoded from the sequencer state
    always_comb begin
        csp_inc = (state == ST_PUSH1) || (state == ST_PUSH2);
        csp_dec = (state == ST_EXEC) && (opcode == cspc_pkg::OP_SUB_RET
            || opcode == cspc_pkg::OP_INTR_RET) || (state == ST_POP2);
        csp_load = (state == ST_EXEC) && (opcode == cspc_pkg::OP_LOAD_CSP);
        dsp_dec = (state == ST_EXEC) && (opcode == cspc_pkg::OP_PUSH_A);
        dsp_inc = (state == ST_EXEC) && (opcode == cspc_pkg::OP_POP_A);
        dsp_load = (state == ST_EXEC) && (opcode == cspc_pkg::OP_SWAP_A_DSP);
    end

    // main sequencer; interrupt acknowledged only between instructions
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state <= ST_FETCH;
            instr_pointer <= cspc_pkg::IP_RESET;
            opcode <= cspc_pkg::DATA_RESET;
            operand <= cspc_pkg::DATA_RESET;
            wait_cnt <= 5'h00;
            hold_byte <= cspc_pkg::DATA_RESET;
            is_intr <= 1'b0;
            is_iret <= 1'b0;
            intr_ack_o <= 1'b0;
        end else begin
            intr_ack_o <= 1'b0;
            case (state)
                ST_FETCH: begin
                    wait_cnt <= 5'h01;
                    is_iret <= 1'b0;
                    if (intr_req_i && intr_en_o) begin
                        is_intr <= 1'b1;
                        intr_ack_o <= 1'b1;
                        hold_byte <= {carry_o, zero_o, instr_pointer[13:8]};
                        state <= ST_PUSH1;
                    end else begin
                        is_intr <= 1'b0;
                        instr_pointer <= step_ip(instr_pointer);
                        state <= ST_OPER;
                    end
                end
                ST_OPER: begin
                    opcode <= prog_data_i;
                    wait_cnt <= wait_cnt + 5'h01;
                    state <= ST_EXEC;
                end
                ST_EXEC: begin
                    wait_cnt <= wait_cnt + 5'h01;
                    if (two_byte(opcode)) begin
                        operand <= prog_data_i;
                        instr_pointer <= step_ip(instr_pointer);
                    end
                    state <= ST_WAIT;
                    if (opcode == cspc_pkg::OP_PAGE_ADV) begin
                        instr_pointer <= {instr_pointer[13:8] + 6'h01, 8'h00};
                    end else if (is_call(opcode)) begin
                        hold_byte <= {carry_o, zero_o, instr_pointer[13:8]};
                        state <= ST_PUSH1;
                    end else if (opcode == cspc_pkg::OP_SUB_RET
                        || opcode == cspc_pkg::OP_INTR_RET) begin
                        is_iret <= (opcode == cspc_pkg::OP_INTR_RET);
                        state <= ST_POP2;
                    end
                end
                ST_PUSH1: begin
                    wait_cnt <= wait_cnt + 5'h01;
                    state <= ST_PUSH2;
                end
                ST_PUSH2: begin
                    wait_cnt <= wait_cnt + 5'h01;
                    if (is_intr) begin
                        instr_pointer <= {6'h00, 8'h00};
                        state <= ST_FETCH;
                    end else begin
                        instr_pointer <= {opcode[3:0], 2'b00, operand}; // jump to target
                        state <= ST_WAIT;
                    end
                end
                ST_POP2: begin
                    wait_cnt <= wait_cnt + 5'h01;
                    state <= ST_POP1;
                end
                ST_POP1: begin
                    wait_cnt <= wait_cnt + 5'h01;
                    hold_byte <= ram_rdata_i; // low byte of the return address
                    state <= ST_WAIT;
                end
                ST_WAIT: begin
                    wait_cnt <= wait_cnt + 5'h01;
                    if (opcode == cspc_pkg::OP_SUB_RET || opcode == cspc_pkg::OP_INTR_RET) begin
                        if (wait_cnt == 5'h05) begin
                            instr_pointer <= {ram_rdata_i[5:0], operand};
                        end
                    end else if (opcode[7:4] >= cspc_pkg::OP_JMP_HI
                        && !is_call(opcode) && wait_cnt == 5'h04) begin
                        instr_pointer <= {opcode[3:0], 2'b00, operand};
                    end
                    if (wait_cnt >= cycles_of(opcode) - 5'h01) begin
                        state <= ST_FETCH;
                    end
                end
                default: state <= ST_FETCH;
            endcase
            // low byte of a return address is on the read bus while in POP1
            if (state == ST_POP1) begin
                operand <= ram_rdata_i;
            end
        end
    end

    // data RAM port: call stack upward, data stack downward
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ram_addr_o <= 8'h00;
            ram_wdata_o <= 8'h00;
            ram_we_o <= 1'b0;
        end else begin
            ram_we_o <= 1'b0;
            if (state == ST_PUSH1) begin
                ram_addr_o <= csp_val;
                ram_wdata_o <= hold_byte;
                ram_we_o <= 1'b1;
            end else if (state == ST_PUSH2) begin
                ram_addr_o <= csp_val;
                ram_wdata_o <= instr_pointer[7:0];
                ram_we_o <= 1'b1;
            end else if (state == ST_POP2 || (state == ST_EXEC && csp_dec)) begin
                ram_addr_o <= csp_val - 8'h01;
            end else if (state == ST_EXEC && opcode == cspc_pkg::OP_PUSH_A) begin
                ram_addr_o <= dsp_val - 8'h01;
                ram_wdata_o <= acc_o;
                ram_we_o <= 1'b1;
            end else if (state == ST_EXEC && opcode == cspc_pkg::OP_POP_A) begin
                ram_addr_o <= dsp_val;
            end else if (state == ST_EXEC && opcode == cspc_pkg::OP_MOV_A_IDX) begin
                ram_addr_o <= prog_data_i + index_o;
            end else if (state == ST_EXEC) begin
                ram_addr_o <= prog_data_i;
            end
        end
    end

    // I/O port access strobes
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            io_addr_o <= 8'h00;
            io_wdata_o <= 8'h00;
            io_we_o <= 1'b0;
            io_re_o <= 1'b0;
        end else begin
            io_we_o <= 1'b0;
            io_re_o <= 1'b0;
            if (state == ST_WAIT && wait_cnt == 5'h03) begin
                if (opcode == cspc_pkg::OP_PORT_RD) begin
                    io_addr_o <= operand;
                    io_re_o <= 1'b1;
                end else if (opcode == cspc_pkg::OP_PORT_WR) begin
                    io_addr_o <= operand;
                    io_wdata_o <= acc_o;
                    io_we_o <= 1'b1;
                end else if (opcode == cspc_pkg::OP_PORT_WRX) begin
                    io_addr_o <= operand + index_o;
                    io_wdata_o <= acc_o;
                    io_we_o <= 1'b1;
                end
            end
        end
    end

    // accumulator and index register
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            acc_o <= cspc_pkg::DATA_RESET;
            index_o <= cspc_pkg::DATA_RESET;
        end else if (state == ST_EXEC && opcode == cspc_pkg::OP_SWAP_A_DSP) begin
            acc_o <= data_sp_o; // old pointer; the load lands on this same edge
        end else if (state == ST_WAIT && wait_cnt == 5'h03) begin
            case (opcode)
                cspc_pkg::OP_MOV_A_DATA: acc_o <= operand;
                cspc_pkg::OP_MOV_X_DATA: index_o <= operand;
                cspc_pkg::OP_MOV_A_X: acc_o <= index_o;
                cspc_pkg::OP_MOV_X_A: index_o <= acc_o;
                default: acc_o <= acc_o;
            endcase
        end else if (state == ST_WAIT && wait_cnt == 5'h04) begin
            // RAM data is back one cycle after the address left in the execute cycle
            case (opcode)
                cspc_pkg::OP_MOV_A_DIR: acc_o <= ram_rdata_i;
                cspc_pkg::OP_MOV_X_DIR: index_o <= ram_rdata_i;
                cspc_pkg::OP_MOV_A_IDX: acc_o <= ram_rdata_i;
                cspc_pkg::OP_POP_A: acc_o <= ram_rdata_i;
                default: acc_o <= acc_o;
            endcase
        end else if (io_re_o) begin
            acc_o <= io_rdata_i;
        end
    end

    // flags and interrupt enable; flags come back only through the interrupt return
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            carry_o <= 1'b0;
            zero_o <= 1'b0;
            intr_en_o <= 1'b0;
        end else begin
            if (state == ST_FETCH && intr_req_i && intr_en_o) begin
                intr_en_o <= 1'b0;
            end else if (state == ST_WAIT && is_iret && wait_cnt == 5'h05) begin
                carry_o <= ram_rdata_i[7];
                zero_o <= ram_rdata_i[6];
                intr_en_o <= 1'b1;
            end else if (state == ST_EXEC && opcode == cspc_pkg::OP_EN_INT) begin
                intr_en_o <= 1'b1;
            end else if (state == ST_EXEC && opcode == cspc_pkg::OP_DIS_INT) begin
                intr_en_o <= 1'b0;
            end
        end
    end

    AST_CSP_RESET: assert property (@(posedge core_clk_i)
        $past(rst_i) |-> call_sp_o == 8'h00 && data_sp_o == 8'h00)
        else $error("stack pointers not zero after reset");
    AST_IP_RESET: assert property (@(posedge core_clk_i)
        $past(rst_i) |-> prog_addr_o == 14'h0000)
        else $error("instruction pointer not cleared");
    AST_NO_CARRY: assert property (@(posedge core_clk_i) disable iff (rst_i)
        state == ST_FETCH |=> prog_addr_o[13:8] == $past(prog_addr_o[13:8]))
        else $error("fetch carried into page bits");
    AST_PAGE: assert property (@(posedge core_clk_i) disable iff (rst_i)
        state == ST_EXEC && opcode == 8'h1F |=> prog_addr_o[13:8] == $past(prog_addr_o[13:8]) + 6'h01)
        else $error("page advance failed");
    AST_PUSH2: assert property (@(posedge core_clk_i) disable iff (rst_i)
        state == ST_PUSH1 |=> ##1 call_sp_o == $past(call_sp_o, 2) + 8'h02)
        else $error("call stack not advanced by two");
    AST_INT_OFF: assert property (@(posedge core_clk_i) disable iff (rst_i)
        intr_ack_o |-> !intr_en_o)
        else $error("interrupts still enabled after acknowledge");
    AST_LOAD: assert property (@(posedge core_clk_i) disable iff (rst_i)
        csp_load |=> call_sp_o == $past(acc_o))
        else $error("call stack pointer not loaded");
    AST_PUSH_DSP: assert property (@(posedge core_clk_i) disable iff (rst_i)
        dsp_dec |=> ram_we_o && ram_addr_o == data_sp_o)
        else $error("data push address wrong");
    AST_FLAGS: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !(state == ST_WAIT && is_iret) |=> $stable(carry_o) && $stable(zero_o))
        else $error("flags changed outside interrupt return");
endmodule : cspc_core

// ---- design/cspc_pkg.sv ----
// constants for the program-flow and stack core: opcodes, cycle counts, reset values
// assumes one core clock with a synchronous active-high reset
package cspc_pkg;
    localparam logic [13:0] IP_RESET = 14'h0000;
    localparam logic [7:0] CSP_RESET = 8'h00;
    localparam logic [7:0] DSP_RESET = 8'h00;
    localparam logic [7:0] OP_MOV_A_DATA = 8'h19;
    localparam logic [7:0] OP_MOV_A_DIR = 8'h1A;
    localparam logic [7:0] OP_MOV_A_IDX = 8'h1B;
    localparam logic [7:0] OP_MOV_X_DATA = 8'h1C;
    localparam logic [7:0] OP_MOV_X_DIR = 8'h1D;
    localparam logic [7:0] OP_PAGE_ADV = 8'h1F;
    localparam logic [7:0] OP_PUSH_A = 8'h2D;
    localparam logic [7:0] OP_POP_A = 8'h2B;
    localparam logic [7:0] OP_PORT_RD = 8'h29;
    localparam logic [7:0] OP_PORT_WR = 8'h2A;
    localparam logic [7:0] OP_PORT_WRX = 8'h39;
    localparam logic [7:0] OP_SUB_RET = 8'h3F;
    localparam logic [7:0] OP_MOV_A_X = 8'h40;
    localparam logic [7:0] OP_MOV_X_A = 8'h41;
    localparam logic [7:0] OP_LOAD_CSP = 8'h60;
    localparam logic [7:0] OP_SWAP_A_DSP = 8'h6E;
    localparam logic [7:0] OP_DIS_INT = 8'h70;
    localparam logic [7:0] OP_EN_INT = 8'h72;
    localparam logic [7:0] OP_INTR_RET = 8'h73;
    localparam logic [7:0] OP_JMP_LO = 8'h80;
    localparam logic [3:0] OP_CALL_A_HI = 4'h5;
    localparam logic [3:0] OP_CALL_B_HI = 4'h9;
    localparam logic [3:0] OP_JMP_HI = 4'h8;
    localparam logic [4:0] CYC_PAGE_ADV = 5'h04;
    localparam logic [4:0] CYC_CALL = 5'h0A;
    localparam logic [4:0] CYC_RET = 5'h08;
    localparam logic [4:0] CYC_LOAD_CSP = 5'h04;
    localparam logic [4:0] CYC_DEFAULT = 5'h04;
    localparam logic [4:0] CYC_DIRECT = 5'h05;
    localparam logic [4:0] CYC_INDEX = 5'h06;
    localparam logic [4:0] CYC_INTR = 5'h0A;
    localparam logic [4:0] CYC_POP = 5'h05;
    localparam logic [4:0] CYC_JMP = 5'h05;
    localparam logic [7:0] DATA_RESET = 8'h00;
endpackage : cspc_pkg

// ---- design/cspc_stack_ptr.sv ----
// one 8-bit stack pointer with increment, decrement and load
// assumes the sequencer never asks for two actions in one cycle
module cspc_stack_ptr #(
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic inc_i,
    input wire logic dec_i,
    input wire logic load_i,
    input wire logic [7:0] load_val_i,
    output logic [7:0] ptr_o
);
    // plain 8-bit arithmetic gives the modulo 256 wrap for free
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ptr_o <= RESET_VAL;
        end else if (load_i) begin
            ptr_o <= load_val_i;
        end else if (inc_i) begin
            ptr_o <= ptr_o + 8'h01;
        end else if (dec_i) begin
            ptr_o <= ptr_o - 8'h01;
        end
    end
endmodule : cspc_stack_ptr

// ---- verif/cspc_mem_model.sv ----
// behavioural program memory, data RAM and I/O space facing the core
// assumes the bench loads rom before reset is released; RAM and ROM answer next cycle
module cspc_mem_model (
    input wire logic core_clk_i,
    input wire logic [13:0] prog_addr_i,
    input wire logic [7:0] ram_addr_i,
    input wire logic [7:0] ram_wdata_i,
    input wire logic ram_we_i,
    input wire logic [7:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    input wire logic io_we_i,
    output logic [7:0] prog_data_o,
    output logic [7:0] ram_rdata_o,
    output logic [7:0] io_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rom [0:16383];
    logic [7:0] ram [0:255];
    logic [7:0] io [0:255];

    // RAM starts with a pattern so a read of an unwritten byte looks like zero only at address 0xA5
    initial begin
        for (int i = 0; i < 256; i++) begin
            ram[i] = 8'hA5 ^ 8'(i);
            io[i] = 8'h00;
        end
    end

    // synchronous ROM and RAM, write-then-read gives the old byte
    always_ff @(posedge core_clk_i) begin
        prog_data_o <= rom[prog_addr_i];
        ram_rdata_o <= ram[ram_addr_i];
        if (ram_we_i) begin
            ram[ram_addr_i] <= ram_wdata_i;
        end
        if (io_we_i) begin
            io[io_addr_i] <= io_wdata_i;
        end
    end

    // I/O reads answer in the same cycle
    assign io_rdata_o = io[io_addr_i];
endmodule : cspc_mem_model

// ---- verif/cpu_stack_program_counter_tb.sv ----
// self-checking bench: one program exercises fetch, stacks, calls, ports, interrupt
// assumes the memory model above and the package opcode constants
module cpu_stack_program_counter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic intr_req_i = 1'b0;
    logic [7:0] prog_data, ram_rdata, io_rdata, ram_addr, ram_wdata, io_addr, io_wdata;
    logic [7:0] acc_o, index_o, call_sp_o, data_sp_o;
    logic [13:0] prog_addr;
    logic ram_we, io_we, intr_ack_o, intr_en_o, carry_o, zero_o;
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;

    cspc_core dut (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .intr_req_i(intr_req_i),
        .prog_data_i(prog_data), .ram_rdata_i(ram_rdata), .io_rdata_i(io_rdata),
        .prog_addr_o(prog_addr), .ram_addr_o(ram_addr), .ram_wdata_o(ram_wdata),
        .ram_we_o(ram_we), .io_addr_o(io_addr), .io_wdata_o(io_wdata), .io_we_o(io_we),
        .io_re_o(), .intr_ack_o(intr_ack_o), .intr_en_o(intr_en_o), .acc_o(acc_o),
        .index_o(index_o), .carry_o(carry_o), .zero_o(zero_o), .call_sp_o(call_sp_o),
        .data_sp_o(data_sp_o)
    );

    cspc_mem_model mem (
        .core_clk_i(core_clk_i), .prog_addr_i(prog_addr), .ram_addr_i(ram_addr),
        .ram_wdata_i(ram_wdata), .ram_we_i(ram_we), .io_addr_i(io_addr),
        .io_wdata_i(io_wdata), .io_we_i(io_we), .prog_data_o(prog_data),
        .ram_rdata_o(ram_rdata), .io_rdata_o(io_rdata)
    );

    // 125 MHz core clock
    initial begin
        forever #4 core_clk_i = ~core_clk_i;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
            n_errors++;
        end
    endtask : check

    task automatic end_sim();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    // the whole program needs well under a thousand cycles; a hang ends here
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 6000) begin
            n_errors++;
            end_sim();
        end
    end

    initial begin
        int a0, r1, acc, idx, dsp, csp, k;
        int ram_e[int];
        int io_e[int];
        logic [7:0] prog [$];
        a0 = $urandom(23) & 255;
        r1 = $urandom & 255;
        // page 0 program; call target is the subroutine at 0x20, jump lands on 0xFF
        prog = {cspc_pkg::OP_MOV_A_DATA, 8'(a0), cspc_pkg::OP_MOV_X_DATA, 8'h05,
                cspc_pkg::OP_PUSH_A, cspc_pkg::OP_PORT_WR, 8'h04, cspc_pkg::OP_PORT_WRX,
                8'h00, cspc_pkg::OP_PORT_RD, 8'h02, cspc_pkg::OP_PUSH_A, 8'h50, 8'h20,
                cspc_pkg::OP_MOV_A_DATA, 8'h06, cspc_pkg::OP_LOAD_CSP, cspc_pkg::OP_POP_A,
                8'h80, 8'hFF};
        for (k = 0; k < 16384; k++) begin
            mem.rom[k] = 8'h00;
        end
        foreach (prog[i]) begin
            mem.rom[i] = prog[i];
        end
        mem.rom[8'h20] = cspc_pkg::OP_SUB_RET;
        // page advance as the last byte of page 0 so either reading lands on 0x0100
        mem.rom[8'hFF] = cspc_pkg::OP_PAGE_ADV;
        // rest of page 1 stays blank: stepping wraps inside the page, so the core idles there
        mem.rom[14'h0100] = cspc_pkg::OP_EN_INT;
        mem.io[8'h02] = 8'(r1); // read-only input port, never written by the program
        // reference model of the same program
        acc = a0;
        idx = 5;
        // this RAM holds no endpoint buffers, so pushing from the reset pointer is allowed
        dsp = 0;
        csp = 0;
        dsp = (dsp - 1) & 255;
        ram_e[dsp] = acc;
        io_e[4] = acc;
        io_e[(idx + 0) & 255] = acc;
        acc = r1;
        dsp = (dsp - 1) & 255;
        ram_e[dsp] = acc;
        ram_e[csp + 1] = 8'h0E;
        csp = csp + 2 - 2;
        csp = 6;
        acc = ram_e[dsp];
        dsp = (dsp + 1) & 255;
        repeat (10) @(posedge core_clk_i);
        #1 rst_i = 1'b0;
        check("ip after reset", 16'(prog_addr), 16'h0000);
        check("csp after reset", 16'(call_sp_o), 16'h0000);
        check("dsp after reset", 16'(data_sp_o), 16'h0000);
        for (k = 0; k < 3000 && prog_addr !== 14'h0101; k++) begin
            @(posedge core_clk_i);
            #1;
        end
        repeat (20) @(posedge core_clk_i);
        #1;
        check("page after advance", 16'(prog_addr[13:8]), 16'h0001);
        check("ram ff", 16'(mem.ram[8'hFF]), 16'(ram_e[255]));
        check("ram fe", 16'(mem.ram[8'hFE]), 16'(ram_e[254]));
        check("io 04", 16'(mem.io[8'h04]), 16'(io_e[4]));
        check("io 05", 16'(mem.io[8'h05]), 16'(io_e[5]));
        check("call low byte", 16'(mem.ram[8'h01]), 16'(ram_e[1]));
        check("call page bits", 16'(mem.ram[8'h00][5:0]), 16'h0000);
        check("csp final", 16'(call_sp_o), 16'(csp));
        check("acc final", 16'(acc_o), 16'(acc));
        check("index", 16'(index_o), 16'(idx));
        check("dsp final", 16'(data_sp_o), 16'(dsp));
        check("int enabled", 16'(intr_en_o), 16'h0001);
        intr_req_i = 1'b1;
        for (k = 0; k < 100 && intr_ack_o !== 1'b1; k++) begin
            @(posedge core_clk_i);
            #1;
        end
        check("int ack", 16'(intr_ack_o), 16'h0001);
        for (k = 0; k < 30 && call_sp_o !== 8'h08; k++) begin
            @(posedge core_clk_i);
            #1;
        end
        intr_req_i = 1'b0;
        check("csp after int", 16'(call_sp_o), 16'(csp + 2));
        check("int disabled", 16'(intr_en_o), 16'h0000);
        check("int page bits", 16'(mem.ram[csp][5:0]), 16'h0001);
        // the vector now holds an interrupt return; both flags are planted in the saved byte
        mem.rom[0] = cspc_pkg::OP_INTR_RET;
        mem.ram[csp] = mem.ram[csp] | 8'hC0;
        repeat (20) @(posedge core_clk_i);
        #1;
        check("csp after intr_return_op", 16'(call_sp_o), 16'(csp));
        check("int reenabled", 16'(intr_en_o), 16'h0001);
        check("page restored", 16'(prog_addr[13:8]), 16'h0001);
        check("carry restored", 16'(carry_o), 16'h0001);
        check("zero restored", 16'(zero_o), 16'h0001);
        end_sim();
    end
endmodule : cpu_stack_program_counter_tb
